/* rtl/sisp_port.v */
`include "sisp_consts.vh"

module sisp_port #(
	parameter [16:0] FLASH_WAIT_CYC = `SISP_FLASH_WAIT_US * `SISP_CLK_MHZ,
	parameter [16:0] EE_WAIT_CYC    = `SISP_EE_WAIT_US * `SISP_CLK_MHZ,
	parameter [16:0] ERASE_WAIT_CYC = `SISP_ERASE_WAIT_US * `SISP_CLK_MHZ,
	parameter [16:0] FUSE_WAIT_CYC  = `SISP_FUSE_WAIT_US * `SISP_CLK_MHZ,
	// Identity and calibration bytes; the values are arbitrary.
	parameter [7:0]  SIG_BYTE0      = 8'h5a,
	parameter [7:0]  SIG_BYTE1      = 8'ha5,
	parameter [7:0]  SIG_BYTE2      = 8'h3c,
	parameter [7:0]  CAL_BYTE       = 8'h80
) (
	// System clock and synchronous reset.
	input  wire       clk,
	input  wire       rst_n,
	// Programming pins.
	input  wire       isp_reset_n,
	input  wire       sck,
	input  wire       mosi,
	output reg        miso,
	output wire       miso_oe_n,
	// Device status.
	output wire       run_normal,
	output reg        prog_enabled,
	output wire       pending_operation_flag,
	output reg        frame_lost,
	// Configuration bytes.
	output reg  [7:0] lock_bits,
	output reg  [7:0] fuse_low,
	output reg  [7:0] fuse_high,
	output reg  [7:0] fuse_ext
);

	// ****************************************
	// Pin synchronisers
	// ****************************************

	localparam [1:0] S_IDLE  = 2'h0;
	localparam [1:0] S_ERASE = 2'h1;
	localparam [1:0] S_FPAGE = 2'h2;
	localparam [1:0] S_EPAGE = 2'h3;

	reg        sck_s1;
	reg        sck_s2;
	reg        sck_d;
	reg        mosi_s1;
	reg        mosi_s2;
	reg        rstp_s1;
	reg        rstp_s2;
	wire       sck_rise;
	wire       sck_fall;
	wire       session;

	// Two flip-flops on each pin before any logic looks at it.
	always @(posedge clk) begin
		if (!rst_n) begin
			sck_s1  <= 1'b0;
			sck_s2  <= 1'b0;
			sck_d   <= 1'b0;
			mosi_s1 <= 1'b0;
			mosi_s2 <= 1'b0;
			rstp_s1 <= 1'b1;
			rstp_s2 <= 1'b1;
		end else begin
			sck_s1  <= sck;
			sck_s2  <= sck_s1;
			sck_d   <= sck_s2;
			mosi_s1 <= mosi;
			mosi_s2 <= mosi_s1;
			rstp_s1 <= isp_reset_n;
			rstp_s2 <= rstp_s1;
		end
	end

	// Edges of the sampled serial clock and the programming session level.
	assign sck_rise   = sck_s2 & ~sck_d;
	assign sck_fall   = ~sck_s2 & sck_d;
	assign session    = ~rstp_s2;
	assign run_normal = rstp_s2;
	assign miso_oe_n  = ~session;

	// ****************************************
	// Byte receiver and FIFO
	// ****************************************

	reg  [2:0] bitcnt;
	reg  [6:0] rx_sh;
	wire       rx_valid;
	wire [7:0] rx_byte;
	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire       fifo_out_ready;
	wire [7:0] cur;

	assign rx_valid = session & sck_rise & (bitcnt == 3'h7);
	assign rx_byte  = {rx_sh, mosi_s2};

	// Shift in on each rising edge, MSB first; framing drops outside a session.
	always @(posedge clk) begin
		if (!rst_n || !session) begin
			bitcnt <= 3'h0;
			rx_sh  <= 7'h00;
		end else if (sck_rise) begin
			bitcnt <= bitcnt + 3'h1;
			rx_sh  <= {rx_sh[5:0], mosi_s2};
		end
	end

	sisp_fifo #(
		.W  (8),
		.D  (4),
		.AW (2)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.clear     (~session),
		.in_valid  (rx_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_byte),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (cur)
	);

	// ****************************************
	// Instruction decoder
	// ****************************************

	reg  [1:0]  idx;
	reg  [7:0]  b1;
	reg  [7:0]  b2;
	reg  [7:0]  b3;
	reg  [7:0]  out_byte;
	reg         rd_pend;
	reg  [7:0]  rd_mux;
	reg  [1:0]  seq;
	reg  [11:0] cnt;
	reg  [16:0] wait_cnt;
	reg  [5:0]  fpage;
	reg  [5:0]  epage;
	reg  [7:0]  ee_buf [0:3];
	reg  [3:0]  ee_ld;
	wire        pop;
	wire        exec;
	wire        wr_ok;
	wire        is_read;
	wire        is_cfg;
	wire [7:0]  flo_q;
	wire [7:0]  fhi_q;
	wire [7:0]  plo_q;
	wire [7:0]  phi_q;
	wire [7:0]  ee_q;

	// Bytes drain all through a session; sweeps hold back writes only, so polls still answer.
	assign fifo_out_ready = session;
	assign pop            = fifo_out_valid & fifo_out_ready;
	assign exec           = pop & (idx == 2'h3) & ~frame_lost;
	assign pending_operation_flag = (seq != S_IDLE) | (wait_cnt != 17'h00000);
	assign wr_ok          = exec & prog_enabled & ~pending_operation_flag;
	assign is_cfg         = (b1 == `SISP_OP_CONFIG);
	assign is_read        = (b1 == `SISP_OP_READ_HI) | (b1 == `SISP_OP_READ_LO) |
		(b1 == `SISP_OP_EE_READ) | (b1 == `SISP_OP_RD_LOCK_FHI) |
		(b1 == `SISP_OP_RD_FLO_FEXT) | (b1 == `SISP_OP_RD_SIG) |
		(b1 == `SISP_OP_RD_CAL) | (b1 == `SISP_OP_POLL);

	// Overflow of the byte FIFO means the framing can no longer be trusted.
	always @(posedge clk) begin
		if (!rst_n || !session) begin
			frame_lost <= 1'b0;
		end else if (rx_valid && !fifo_in_ready) begin
			frame_lost <= 1'b1;
		end
	end

	// Byte position and captured bytes of the instruction in progress.
	always @(posedge clk) begin
		if (!rst_n || !session) begin
			idx <= 2'h0;
			b1  <= 8'h00;
			b2  <= 8'h00;
			b3  <= 8'h00;
		end else if (pop) begin
			idx <= idx + 2'h1;
			case (idx)
				2'h0: begin
					b1 <= cur;
				end
				2'h1: begin
					b2 <= cur;
				end
				2'h2: begin
					b3 <= cur;
				end
				default: begin
					b3 <= b3;
				end
			endcase
		end
	end

	// A read is started when the third byte arrives and answered next cycle.
	always @(posedge clk) begin
		if (!rst_n) begin
			rd_pend <= 1'b0;
		end else begin
			rd_pend <= pop & (idx == 2'h2) & is_read & prog_enabled & ~frame_lost;
		end
	end

	// Answer byte for the fourth position of each read.
	always @* begin
		case (b1)
			`SISP_OP_READ_HI:     rd_mux = fhi_q;
			`SISP_OP_READ_LO:     rd_mux = flo_q;
			`SISP_OP_EE_READ:     rd_mux = ee_q;
			`SISP_OP_RD_LOCK_FHI: rd_mux = b2[`SISP_FUSE_SEL_BIT] ? fuse_high : lock_bits;
			`SISP_OP_RD_FLO_FEXT: rd_mux = b2[`SISP_FUSE_SEL_BIT] ? fuse_ext : fuse_low;
			`SISP_OP_RD_CAL:      rd_mux = CAL_BYTE;
			`SISP_OP_POLL:        rd_mux = {7'h00, pending_operation_flag};
			`SISP_OP_RD_SIG: begin
				case (b3[1:0])
					2'h0:    rd_mux = SIG_BYTE0;
					2'h1:    rd_mux = SIG_BYTE1;
					default: rd_mux = SIG_BYTE2;
				endcase
			end
			default:              rd_mux = out_byte;
		endcase
	end

	// ****************************************
	// Serial output
	// ****************************************

	// Each received byte is echoed one byte later; reads replace byte four.
	always @(posedge clk) begin
		if (!rst_n) begin
			out_byte <= 8'h00;
		end else if (rd_pend) begin
			out_byte <= rd_mux;
		end else if (pop) begin
			out_byte <= cur;
		end
	end

	// MISO moves on falling edges; a fresh byte before its first fall shows bit 7.
	always @(posedge clk) begin
		if (!rst_n || !session) begin
			miso <= 1'b0;
		end else if (sck_fall) begin
			miso <= out_byte[~bitcnt];
		end else if (rd_pend && bitcnt == 3'h0) begin
			miso <= rd_mux[7];
		end else if (pop && bitcnt == 3'h0) begin
			miso <= cur[7];
		end
	end

	// ****************************************
	// Execution and configuration bytes
	// ****************************************

	// Enable and configuration writes happen when the fourth byte arrives.
	always @(posedge clk) begin
		if (!rst_n) begin
			prog_enabled <= 1'b0;
			lock_bits    <= `SISP_LOCK_RESET;
			fuse_low     <= `SISP_FLO_RESET;
			fuse_high    <= `SISP_FHI_RESET;
			fuse_ext     <= `SISP_FEXT_RESET;
		end else if (!session) begin
			prog_enabled <= 1'b0;
		end else begin
			if (exec && is_cfg && b2 == `SISP_SUB_ENABLE) begin
				prog_enabled <= 1'b1;
			end
			if (wr_ok && is_cfg && b2 == `SISP_SUB_ERASE) begin
				lock_bits <= `SISP_LOCK_RESET;
			end
			// Lock writes can only move bits towards programmed, which is zero.
			if (wr_ok && is_cfg && b2 == `SISP_SUB_LOCK_WR) begin
				lock_bits <= lock_bits & cur;
			end
			if (wr_ok && is_cfg && b2 == `SISP_SUB_FLO_WR) begin
				fuse_low <= cur;
			end
			if (wr_ok && is_cfg && b2 == `SISP_SUB_FHI_WR) begin
				fuse_high <= cur;
			end
			if (wr_ok && is_cfg && b2 == `SISP_SUB_FEXT_WR) begin
				fuse_ext <= cur;
			end
		end
	end

	// EEPROM page buffer keeps a loaded mark per byte.
	always @(posedge clk) begin
		if (!rst_n) begin
			ee_ld <= 4'h0;
		end else if (seq == S_EPAGE && cnt == `SISP_EPAGE_LAST) begin
			ee_ld <= 4'h0;
		end else if (wr_ok && b1 == `SISP_OP_EE_LOAD) begin
			ee_ld[b3[1:0]]  <= 1'b1;
			ee_buf[b3[1:0]] <= cur;
		end
	end

	// Sweep sequencer for erase and page commits, plus the write wait timer.
	// The extended address opcode is accepted as a no-op: this size needs none.
	always @(posedge clk) begin
		if (!rst_n) begin
			seq      <= S_IDLE;
			cnt      <= 12'h000;
			wait_cnt <= 17'h00000;
			fpage    <= 6'h00;
			epage    <= 6'h00;
		end else begin
			if (wait_cnt != 17'h00000) begin
				wait_cnt <= wait_cnt - 17'h00001;
			end
			case (seq)
				S_IDLE: begin
					cnt <= 12'h000;
					if (wr_ok && is_cfg && b2 == `SISP_SUB_ERASE) begin
						seq      <= S_ERASE;
						wait_cnt <= ERASE_WAIT_CYC;
					end else if (wr_ok && is_cfg && {b2[7:4], 4'h0} == `SISP_SUB_FLO_WR) begin
						wait_cnt <= FUSE_WAIT_CYC;
					end else if (wr_ok && b1 == `SISP_OP_PAGE_WR) begin
						seq      <= S_FPAGE;
						fpage    <= {b2[2:0], b3[7:5]};
						wait_cnt <= FLASH_WAIT_CYC;
					end else if (wr_ok && b1 == `SISP_OP_EE_WR) begin
						wait_cnt <= EE_WAIT_CYC;
					end else if (wr_ok && b1 == `SISP_OP_EE_PAGE_WR) begin
						seq      <= S_EPAGE;
						epage    <= b3[7:2];
						wait_cnt <= EE_WAIT_CYC;
					end else if (wr_ok && b1 == `SISP_OP_EXT_ADDR) begin
						seq <= S_IDLE;
					end
				end
				S_ERASE: begin
					cnt <= cnt + 12'h001;
					if (cnt == `SISP_ERASE_LAST) begin
						seq <= S_IDLE;
					end
				end
				S_FPAGE: begin
					cnt <= cnt + 12'h001;
					if (cnt == `SISP_FPAGE_LAST) begin
						seq <= S_IDLE;
					end
				end
				S_EPAGE: begin
					cnt <= cnt + 12'h001;
					if (cnt == `SISP_EPAGE_LAST) begin
						seq <= S_IDLE;
					end
				end
				default: begin
					seq <= S_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Memory arrays
	// ****************************************

	reg  [10:0] flash_a;
	reg         flash_we;
	reg  [7:0]  flash_lo_d;
	reg  [7:0]  flash_hi_d;
	reg  [7:0]  ee_a;
	reg         ee_we;
	reg  [7:0]  ee_d;
	wire [11:0] cnt_m1;
	wire [4:0]  pbuf_a;

	assign cnt_m1 = cnt - 12'h001;
	assign pbuf_a = (seq == S_FPAGE) ? cnt[4:0] : b3[4:0];

	// Flash port: erase sweep, page copy one cycle behind the buffer read, or a read.
	always @* begin
		flash_we   = 1'b0;
		flash_lo_d = plo_q;
		flash_hi_d = phi_q;
		flash_a    = {b2[2:0], cur};
		if (seq == S_ERASE) begin
			flash_we   = 1'b1;
			flash_a    = cnt[10:0];
			flash_lo_d = `SISP_ERASED;
			flash_hi_d = `SISP_ERASED;
		end else if (seq == S_FPAGE) begin
			flash_we = (cnt != 12'h000);
			flash_a  = {fpage, cnt_m1[4:0]};
		end
	end

	// EEPROM port: erase sweep, loaded bytes of a page, a byte write, or a read.
	always @* begin
		ee_we = 1'b0;
		ee_d  = cur;
		ee_a  = (idx == 2'h3) ? b3 : cur;
		if (seq == S_ERASE) begin
			ee_we = (cnt[11:8] == `SISP_EE_ERASE_TOP);
			ee_a  = cnt[7:0];
			ee_d  = `SISP_ERASED;
		end else if (seq == S_EPAGE) begin
			ee_we = ee_ld[cnt[1:0]];
			ee_a  = {epage, cnt[1:0]};
			ee_d  = ee_buf[cnt[1:0]];
		end else if (wr_ok && b1 == `SISP_OP_EE_WR) begin
			ee_we = 1'b1;
		end
	end

	sisp_mem #(.AW(11), .DW(8)) u_flash_lo (
		.clk   (clk),
		.we    (flash_we),
		.addr  (flash_a),
		.wdata (flash_lo_d),
		.rdata (flo_q)
	);

	sisp_mem #(.AW(11), .DW(8)) u_flash_hi (
		.clk   (clk),
		.we    (flash_we),
		.addr  (flash_a),
		.wdata (flash_hi_d),
		.rdata (fhi_q)
	);

	sisp_mem #(.AW(5), .DW(8)) u_pbuf_lo (
		.clk   (clk),
		.we    (wr_ok && b1 == `SISP_OP_LOAD_LO),
		.addr  (pbuf_a),
		.wdata (cur),
		.rdata (plo_q)
	);

	sisp_mem #(.AW(5), .DW(8)) u_pbuf_hi (
		.clk   (clk),
		.we    (wr_ok && b1 == `SISP_OP_LOAD_HI),
		.addr  (pbuf_a),
		.wdata (cur),
		.rdata (phi_q)
	);

	sisp_mem #(.AW(8), .DW(8)) u_eeprom (
		.clk   (clk),
		.we    (ee_we),
		.addr  (ee_a),
		.wdata (ee_d),
		.rdata (ee_q)
	);

endmodule

/* rtl/sisp_consts.vh */
`ifndef SISP_CONSTS_VH
`define SISP_CONSTS_VH

// First and second instruction bytes.
`define SISP_OP_CONFIG      8'hac
`define SISP_SUB_ENABLE     8'h53
`define SISP_SUB_ERASE      8'h80
`define SISP_SUB_LOCK_WR    8'he0
`define SISP_SUB_FLO_WR     8'ha0
`define SISP_SUB_FHI_WR     8'ha8
`define SISP_SUB_FEXT_WR    8'ha4
`define SISP_OP_POLL        8'hf0
`define SISP_OP_EXT_ADDR    8'h4d
`define SISP_OP_LOAD_HI     8'h48
`define SISP_OP_LOAD_LO     8'h40
`define SISP_OP_EE_LOAD     8'hc1
`define SISP_OP_READ_HI     8'h28
`define SISP_OP_READ_LO     8'h20
`define SISP_OP_EE_READ     8'ha0
`define SISP_OP_RD_LOCK_FHI 8'h58
`define SISP_OP_RD_FLO_FEXT 8'h50
`define SISP_OP_RD_SIG      8'h30
`define SISP_OP_RD_CAL      8'h38
`define SISP_OP_PAGE_WR     8'h4c
`define SISP_OP_EE_WR       8'hc0
`define SISP_OP_EE_PAGE_WR  8'hc2
// Bit of the second byte that picks the high or extended fuse on reads.
`define SISP_FUSE_SEL_BIT   3

// Reset values of the configuration bytes and the erased value.
`define SISP_LOCK_RESET     8'hff
`define SISP_FLO_RESET      8'h62
`define SISP_FHI_RESET      8'hdf
`define SISP_FEXT_RESET     8'hff
`define SISP_ERASED         8'hff

// Clock rate and write wait times in microseconds.
`define SISP_CLK_MHZ        10
`define SISP_FLASH_WAIT_US  4500
`define SISP_EE_WAIT_US     4000
`define SISP_ERASE_WAIT_US  9000
`define SISP_FUSE_WAIT_US   4500

// Last step of each internal sweep, and the top count nibble that erases the EEPROM.
`define SISP_ERASE_LAST     12'h7ff
`define SISP_FPAGE_LAST     12'h020
`define SISP_EPAGE_LAST     12'h003
`define SISP_EE_ERASE_TOP   4'h0

`endif

/* rtl/sisp_mem.v */
// ****************************************
// Synchronous single port memory
// ****************************************
module sisp_mem #(
	parameter AW = 8,
	parameter DW = 8
) (
	// Clock.
	input  wire          clk,
	// Access port.
	input  wire          we,
	input  wire [AW-1:0] addr,
	input  wire [DW-1:0] wdata,
	output reg  [DW-1:0] rdata
);

	reg [DW-1:0] cells [0:(1<<AW)-1];

	// Write on strobe and return the addressed word one cycle later.
	always @(posedge clk) begin
		if (we) begin
			cells[addr] <= wdata;
		end
		rdata <= cells[addr];
	end

endmodule

/* rtl/sisp_fifo.v */
// ****************************************
// Byte FIFO with valid and ready on both sides
// ****************************************
module sisp_fifo #(
	parameter W  = 8,
	parameter D  = 4,
	parameter AW = 2
) (
	// Clock, reset and flush.
	input  wire         clk,
	input  wire         rst_n,
	input  wire         clear,
	// Filling side.
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// Draining side.
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);

	localparam [AW:0] DEPTH = D;

	reg  [W-1:0] store [0:D-1];
	reg  [AW:0]  wr_ptr;
	reg  [AW:0]  rd_ptr;
	wire [AW:0]  level;

	// Full and empty follow from the pointer distance.
	assign level     = wr_ptr - rd_ptr;
	assign in_ready  = (level != DEPTH);
	assign out_valid = (level != {(AW+1){1'b0}});
	assign out_data  = store[rd_ptr[AW-1:0]];

	// Pointers move on each accepted transfer.
	always @(posedge clk) begin
		if (!rst_n || clear) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && in_ready) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// Storage is written without reset.
	always @(posedge clk) begin
		if (in_valid && in_ready) begin
			store[wr_ptr[AW-1:0]] <= in_data;
		end
	end

endmodule

/* testbench/sisp_port_sva.sv */
`include "sisp_consts.vh"

// ****************************************
// Checker on the programming port pins
// ****************************************
module sisp_port_sva #(
	parameter [16:0] ERASE_WAIT_CYC = 17'd90000
) (
	// Clock and reset.
	input wire       clk,
	input wire       rst_n,
	// Pins and status.
	input wire       isp_reset_n,
	input wire       miso_oe_n,
	input wire       run_normal,
	input wire       prog_enabled,
	input wire       pending_operation_flag,
	input wire       frame_lost,
	// Configuration bytes.
	input wire [7:0] lock_bits,
	input wire [7:0] fuse_low,
	input wire [7:0] fuse_high,
	input wire [7:0] fuse_ext
);
	localparam int PEND_CAP = ERASE_WAIT_CYC + 2100;
	reg [17:0] pend_cyc;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Counts how long the pending flag has stood without a break.
	always @(posedge clk) begin
		if (!rst_n || !pending_operation_flag) pend_cyc <= 18'h0;
		else pend_cyc <= pend_cyc + 18'h1;
	end

	reset_vals_a: assert property (disable iff (1'b0) !rst_n |=> !prog_enabled
		&& !frame_lost && !pending_operation_flag && fuse_low == `SISP_FLO_RESET
		&& fuse_high == `SISP_FHI_RESET && fuse_ext == `SISP_FEXT_RESET)
		else $error("configuration not at reset value");
	oe_tracks_a: assert property ($past(rst_n) && $past(rst_n, 2) |->
		miso_oe_n == $past(isp_reset_n, 2) && run_normal == miso_oe_n)
		else $error("output enable disagrees with session state");
	pin_sync_a: assert property ($rose(isp_reset_n) |-> ##[1:3] run_normal)
		else $error("normal run not entered after pin high");
	enable_drop_a: assert property ($rose(run_normal) |-> ##[0:2] !prog_enabled)
		else $error("programming stays enabled after session end");
	frame_drop_a: assert property ($rose(run_normal) |-> ##[0:2] !frame_lost)
		else $error("framing loss not dropped on pin pulse");
	fuse_guard_a: assert property ($changed(fuse_low) |-> $past(prog_enabled))
		else $error("low fuse changed without enable");
	lock_guard_a: assert property ($changed(lock_bits) |-> $past(prog_enabled))
		else $error("lock bits changed without enable");
	pend_guard_a: assert property ($rose(pending_operation_flag) |-> prog_enabled)
		else $error("operation started without enable");
	pend_bound_a: assert property (pend_cyc <= PEND_CAP)
		else $error("pending flag stands too long");
endmodule

bind sisp_port sisp_port_sva #(.ERASE_WAIT_CYC(ERASE_WAIT_CYC)) sisp_port_sva_inst (
	.clk(clk), .rst_n(rst_n), .isp_reset_n(isp_reset_n), .miso_oe_n(miso_oe_n),
	.run_normal(run_normal), .prog_enabled(prog_enabled),
	.pending_operation_flag(pending_operation_flag), .frame_lost(frame_lost),
	.lock_bits(lock_bits), .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext));

/* testbench/sisp_prog.sv */
// ****************************************
// External programmer model
// ****************************************
module sisp_prog #(
	parameter int PWR_WAIT_CYC = 200000
) (
	// System clock and data back from the device.
	input  wire clk,
	input  wire miso,
	// Pins driven toward the device.
	output reg  isp_reset_n,
	output reg  sck,
	output reg  mosi
);
	timeunit 1ns;
	timeprecision 1ns;

	// The link idles with its clock low and the session pin low.
	initial begin
		isp_reset_n = 1'b0;
		sck = 1'b0;
		mosi = 1'b0;
	end

	// One serial clock phase lasts four system clocks.
	task automatic half;
		repeat (4) @(negedge clk);
	endtask

	// Waits out the power-up time before the first instruction.
	task automatic power_up;
		repeat (PWR_WAIT_CYC) @(negedge clk);
	endtask

	// Sets the session pin and holds it for ten clocks.
	task automatic pin(input bit v);
		isp_reset_n = v;
		repeat (10) @(negedge clk);
	endtask

	// Shifts the top nb bits of tx, capturing the device output on each rise.
	task automatic shift(input [31:0] tx, input int nb, output [31:0] rx);
		int i;
		rx = 32'h0;
		for (i = 31; i > 31 - nb; i--) begin
			mosi = tx[i];
			half;
			sck = 1'b1;
			rx[i] = miso;
			half;
			sck = 1'b0;
		end
		mosi = ~mosi; // A released data line keeps no stale value.
		half;
	endtask

	// Polls the pending bit until it clears, giving up after 40 tries.
	task automatic poll(output [31:0] rx);
		int n;
		n = 0;
		rx = 32'h1;
		while (rx[0] !== 1'b0 && n < 40) begin
			shift(32'hf000_0000, 32, rx);
			n++;
		end
	endtask
endmodule

/* testbench/sisp_port_tb_top.sv */
// ****************************************
// Programming port testbench
// ****************************************
module sisp_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [16:0] WAIT_CYC = 17'd3000;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	wire        isp_reset_n, sck, mosi, miso, miso_oe_n, run_normal;
	wire        prog_enabled, pend_flag, frame_lost;
	wire [7:0]  lock_bits, fuse_low, fuse_high, fuse_ext;
	int         fails = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	reg  [31:0] rx;

	sisp_port #(.FLASH_WAIT_CYC(WAIT_CYC), .EE_WAIT_CYC(WAIT_CYC), .ERASE_WAIT_CYC(WAIT_CYC),
		.FUSE_WAIT_CYC(WAIT_CYC)) sisp_port_inst (.clk(clk), .rst_n(rst_n),
		.isp_reset_n(isp_reset_n), .sck(sck), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
		.run_normal(run_normal), .prog_enabled(prog_enabled), .pending_operation_flag(pend_flag),
		.frame_lost(frame_lost), .lock_bits(lock_bits), .fuse_low(fuse_low),
		.fuse_high(fuse_high), .fuse_ext(fuse_ext));
	sisp_prog #(.PWR_WAIT_CYC(20)) sisp_prog_inst (.clk(clk), .miso(miso),
		.isp_reset_n(isp_reset_n), .sck(sck), .mosi(mosi));

	// The system clock runs at 10 MHz.
	initial begin
		forever #50 clk = ~clk;
	end

	// Cuts a hung run short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			fails++;
			print_verdict;
		end
	end

	task automatic cmp8(input string what, input [7:0] exp, input [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp1(input string what, input exp, input got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic ins(input [31:0] tx);
		sisp_prog_inst.shift(tx, 32, rx);
	endtask

	task automatic settle;
		sisp_prog_inst.poll(rx);
		cmp1("pending bit", 1'b0, rx[0]);
		cmp1("pending pin", 1'b0, pend_flag);
	endtask

	task automatic rd(input string what, input [31:0] tx, input [7:0] exp);
		ins(tx);
		cmp8(what, exp, rx[7:0]);
	endtask

	task automatic t_enable;
		ins(32'haca0_0011);
		cmp1("enable before", 1'b0, prog_enabled);
		ins(32'hac53_0000);
		cmp8("echo of first", 8'hac, rx[23:16]);
		cmp8("echo of second", 8'h53, rx[15:8]);
		cmp1("enabled", 1'b1, prog_enabled);
		cmp1("oe in session", 1'b0, miso_oe_n);
		cmp8("refused fuse", 8'h62, fuse_low);
		$display("enable test done");
	endtask

	task automatic t_erase;
		ins(32'hac80_0000);
		cmp1("pending pin busy", 1'b1, pend_flag);
		ins(32'hf000_0000);
		cmp1("busy after erase", 1'b1, rx[0]);
		ins(32'haca0_0011);
		settle;
		cmp8("write while busy", 8'h62, fuse_low);
		rd("flash erased", 32'h2800_0005, 8'hff);
		rd("eeprom erased", 32'ha000_0010, 8'hff);
		$display("erase test done");
	endtask

	task automatic t_flash;
		ins(32'h4000_2534);
		ins(32'h4800_2512);
		ins(32'h4000_3f78);
		ins(32'h4800_3f56);
		ins(32'h4c00_2000);
		settle;
		ins(32'h4d00_0100);
		rd("flash high", 32'h2800_2500, 8'h12);
		rd("flash low", 32'h2000_2500, 8'h34);
		rd("page end low", 32'h2000_3f00, 8'h78);
		rd("page end high", 32'h2800_3f00, 8'h56);
		rd("other page", 32'h2000_0500, 8'hff);
		$display("flash test done");
	endtask

	task automatic t_eeprom;
		ins(32'hc000_100f);
		settle;
		ins(32'hc000_10a5);
		settle;
		rd("byte write", 32'ha000_1000, 8'ha5);
		ins(32'hc100_115c);
		ins(32'hc200_1000);
		settle;
		rd("unloaded kept", 32'ha000_1000, 8'ha5);
		rd("loaded byte", 32'ha000_1100, 8'h5c);
		rd("unloaded slot", 32'ha000_1200, 8'hff);
		$display("eeprom test done");
	endtask

	task automatic t_config;
		bit [31:0] wsub, wdat, rop, rsub;
		int i;
		wsub = 32'he0a0_a8a4;
		wdat = 32'hf03c_d5fe;
		rop = 32'h5850_5850;
		rsub = 32'h0000_0808;
		for (i = 0; i < 4; i++) begin
			ins({8'hac, wsub[31-8*i -: 8], 8'h00, wdat[31-8*i -: 8]});
			settle;
			rd("config read", {rop[31-8*i -: 8], rsub[31-8*i -: 8], 16'h0}, wdat[31-8*i -: 8]);
		end
		cmp8("lock pins", 8'hf0, lock_bits);
		cmp8("low fuse pins", 8'h3c, fuse_low);
		cmp8("high fuse pins", 8'hd5, fuse_high);
		cmp8("ext fuse pins", 8'hfe, fuse_ext);
		rd("signature 0", 32'h3000_0000, 8'h5a);
		rd("signature 2", 32'h3000_0200, 8'h3c);
		rd("calibration", 32'h3800_0000, 8'h80);
		$display("config test done");
	endtask

	task automatic t_resync;
		sisp_prog_inst.shift(32'hff00_0000, 5, rx);
		sisp_prog_inst.pin(1'b1);
		cmp1("normal run", 1'b1, run_normal);
		cmp1("enable dropped", 1'b0, prog_enabled);
		cmp1("oe released", 1'b1, miso_oe_n);
		sisp_prog_inst.pin(1'b0);
		ins(32'haca0_0000);
		ins(32'hac53_0000);
		cmp8("echo after pulse", 8'h53, rx[15:8]);
		rd("fuse kept", 32'h5000_0000, 8'h3c);
		cmp1("no framing loss", 1'b0, frame_lost);
		$display("resync test done");
	endtask

	task automatic print_verdict;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Holds reset for two cycles, then runs every scenario.
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		sisp_prog_inst.power_up;
		t_enable;
		t_erase;
		t_flash;
		t_eeprom;
		t_config;
		t_resync;
		print_verdict;
	end
endmodule
